// File: rtl/tw_pkg.sv
// What this block does
// - control byte upper nibble must match type code
// - next three bits select one of eight
// - select bits kept in nonvolatile image
// - last control bit: one reads, zero writes
// - acknowledge control only on type and select match
// - write: control, acked command, then data bytes
// - read: command, repeated start, control with read
// - command 01 accesses divider register
// - command 02 accesses output mux register
// - command 0D accesses bus configuration register
// - commit bit clear: commit after every write command
// - commit bit set: commit only on 3F or a bus configuration write
// - bus configuration write always commits everything
// - bus byte: bit3 commit, 2..0 select, rest zero
// - nack everything while nonvolatile write runs
// - divider ten bits, divisor is value plus two
// - reject programming during power-down
package tw_pkg;

  localparam logic [7:0] CMD_DIV         = 8'h01;
  localparam logic [7:0] CMD_MUX         = 8'h02;
  localparam logic [7:0] CMD_BUS         = 8'h0D;
  localparam logic [7:0] CMD_COMMIT      = 8'h3F;

  localparam int         BUS_WC_BIT      = 3;
  localparam int         BUS_SEL_LSB     = 0;
  localparam logic [7:0] BUS_KEEP_MASK   = 8'h0F;
  localparam int         DIV_VAL_LSB     = 6;
  localparam logic [10:0] DIV_OFFSET     = 11'h002;

  localparam logic [15:0] DIV_RST        = 16'h0000;
  localparam logic [15:0] MUX_RST        = 16'h0000;
  localparam logic [7:0]  BUS_RST        = 8'h00;

  // nonvolatile write duration in clk cycles
  localparam int         NV_WRITE_CYCLES = 200;

  typedef struct packed {
    logic [15:0] divider_value;
    logic [15:0] output_mux_config;
    logic [7:0]  bus_address_config;
  } tw_regs_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX   = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_TX   = 5'b01000,
    ST_MACK = 5'b10000
  } tw_state_e;

  typedef enum logic [2:0] {
    PH_CTRL = 3'b001,
    PH_CMD  = 3'b010,
    PH_DATA = 3'b100
  } tw_phase_e;

endpackage

// File: rtl/tw_slave.sv
`timescale 1ns/10ps
module tw_slave #(
  parameter logic [3:0] TYPE_CODE       = 4'h5, // arbitrary value
  parameter int         NV_WRITE_CYCLES = tw_pkg::NV_WRITE_CYCLES
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            reset,
  // serial pins
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe,
  // device state
  input  wire logic            power_down,
  // register views
  output tw_pkg::tw_regs_s     regs,
  output tw_pkg::tw_regs_s     nv_image,
  output logic                 nv_busy,
  output logic      [10:0]     divisor
);
  logic              scl_s, sda_s, pd_s, scl_q, sda_q;
  tw_pkg::tw_state_e st_r;
  tw_pkg::tw_phase_e phase_r;
  logic [3:0]        cnt_r;
  logic [7:0]        rx_r, cmd_r, tx_r;
  logic [1:0]        idx_r;
  logic              rw_r, ack_r, mnack_r, wrote_r;
  logic [15:0]       busy_cnt_r;
  logic              scl_rise, scl_fall, start_c, stop_c, byte_end, blocked;
  logic              ctrl_match, wr_stb, commit_end, commit_cmd, commit_bus, commit;
  logic [7:0]        rd_byte;

  tw_sync #(.WIDTH(3), .INIT(3'b110)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({scl_i, sda_i, power_down}),
    .q     ({scl_s, sda_s, pd_s})
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise   = scl_s && !scl_q;
  assign scl_fall   = !scl_s && scl_q;
  assign start_c    = scl_s && scl_q && sda_q && !sda_s;
  assign stop_c     = scl_s && scl_q && !sda_q && sda_s;
  assign byte_end   = scl_fall && st_r == tw_pkg::ST_RX && cnt_r == 4'h8;
  assign blocked    = nv_busy || pd_s;
  assign ctrl_match = rx_r[7:4] == TYPE_CODE &&
                      rx_r[3:1] == regs.bus_address_config[2:0];
  assign wr_stb     = byte_end && phase_r == tw_pkg::PH_DATA && !blocked;
  assign commit_bus = wr_stb && cmd_r == tw_pkg::CMD_BUS;
  assign commit_cmd = byte_end && phase_r == tw_pkg::PH_CMD && !blocked &&
                      rx_r == tw_pkg::CMD_COMMIT;
  assign commit_end = (start_c || stop_c) && wrote_r && !nv_busy &&
                      !regs.bus_address_config[tw_pkg::BUS_WC_BIT];
  assign commit     = commit_bus || commit_cmd || commit_end;

  // read data, high byte first
  always_comb begin
    rd_byte = 8'h00;
    unique case (cmd_r)
      tw_pkg::CMD_DIV: rd_byte = idx_r == 2'h0 ? regs.divider_value[15:8] :
                                 regs.divider_value[7:0];
      tw_pkg::CMD_MUX: rd_byte = idx_r == 2'h0 ? regs.output_mux_config[15:8] :
                                 regs.output_mux_config[7:0];
      tw_pkg::CMD_BUS: rd_byte = regs.bus_address_config;
      default:         rd_byte = 8'h00;
    endcase
  end

  // protocol sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r    <= tw_pkg::ST_IDLE;
      phase_r <= tw_pkg::PH_CTRL;
      cnt_r   <= 4'h0;
      rx_r    <= 8'h00;
      tx_r    <= 8'hFF;
      rw_r    <= 1'b0;
      ack_r   <= 1'b0;
      mnack_r <= 1'b0;
    end else if (stop_c) begin
      st_r <= tw_pkg::ST_IDLE;
    end else if (start_c) begin
      st_r    <= tw_pkg::ST_RX;
      phase_r <= tw_pkg::PH_CTRL;
      cnt_r   <= 4'h0;
      ack_r   <= 1'b0;
    end else begin
      unique case (st_r)
        tw_pkg::ST_IDLE: begin
          cnt_r <= 4'h0;
        end
        tw_pkg::ST_RX: begin
          if (scl_rise && cnt_r != 4'h8) begin
            rx_r  <= {rx_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            st_r <= tw_pkg::ST_ACK;
            if (phase_r == tw_pkg::PH_CTRL) begin
              ack_r <= ctrl_match && !blocked;
              rw_r  <= rx_r[0];
            end else begin
              ack_r <= !blocked;
            end
          end
        end
        tw_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            if (!ack_r) begin
              st_r <= tw_pkg::ST_IDLE;
            end else if (phase_r == tw_pkg::PH_CTRL && rw_r) begin
              st_r <= tw_pkg::ST_TX;
              tx_r <= rd_byte;
            end else begin
              st_r    <= tw_pkg::ST_RX;
              phase_r <= phase_r == tw_pkg::PH_CTRL ? tw_pkg::PH_CMD : tw_pkg::PH_DATA;
            end
          end
        end
        tw_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h7) begin
              st_r <= tw_pkg::ST_MACK;
            end else begin
              tx_r  <= {tx_r[6:0], 1'b1};
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        tw_pkg::ST_MACK: begin
          if (scl_rise) begin
            mnack_r <= sda_s;
          end else if (scl_fall) begin
            cnt_r <= 4'h0;
            if (mnack_r) begin
              st_r <= tw_pkg::ST_IDLE;
            end else begin
              st_r <= tw_pkg::ST_TX;
              tx_r <= rd_byte;
            end
          end
        end
      endcase
    end
  end

  // command byte and byte index
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_r <= 8'h00;
      idx_r <= 2'h0;
    end else if (byte_end && phase_r == tw_pkg::PH_CMD && !blocked) begin
      cmd_r <= rx_r;
      idx_r <= 2'h0;
    end else if (wr_stb || (st_r == tw_pkg::ST_TX && scl_fall && cnt_r == 4'h7)) begin
      idx_r <= idx_r == 2'h3 ? idx_r : idx_r + 2'h1;
    end
  end

  // working registers
  always_ff @(posedge clk) begin
    if (reset) begin
      regs.divider_value      <= tw_pkg::DIV_RST;
      regs.output_mux_config  <= tw_pkg::MUX_RST;
      regs.bus_address_config <= tw_pkg::BUS_RST;
    end else if (wr_stb) begin
      unique case (cmd_r)
        tw_pkg::CMD_DIV: begin
          if (idx_r == 2'h0) regs.divider_value[15:8] <= rx_r;
          if (idx_r == 2'h1) regs.divider_value[7:0]  <= rx_r;
        end
        tw_pkg::CMD_MUX: begin
          if (idx_r == 2'h0) regs.output_mux_config[15:8] <= rx_r;
          if (idx_r == 2'h1) regs.output_mux_config[7:0]  <= rx_r;
        end
        tw_pkg::CMD_BUS: begin
          if (idx_r == 2'h0) regs.bus_address_config <= rx_r & tw_pkg::BUS_KEEP_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // pending write that awaits auto commit
  always_ff @(posedge clk) begin
    if (reset) begin
      wrote_r <= 1'b0;
    end else if (wr_stb) begin
      wrote_r <= 1'b1;
    end else if (start_c || stop_c) begin
      wrote_r <= 1'b0;
    end
  end

  // nonvolatile image and write timer
  always_ff @(posedge clk) begin
    if (reset) begin
      nv_image.divider_value      <= tw_pkg::DIV_RST;
      nv_image.output_mux_config  <= tw_pkg::MUX_RST;
      nv_image.bus_address_config <= tw_pkg::BUS_RST;
      busy_cnt_r                  <= 16'h0000;
    end else if (commit && !nv_busy) begin
      nv_image   <= regs;
      busy_cnt_r <= 16'(NV_WRITE_CYCLES);
      if (commit_bus && idx_r == 2'h0) begin
        nv_image.bus_address_config <= rx_r & tw_pkg::BUS_KEEP_MASK;
      end
    end else if (busy_cnt_r != 16'h0000) begin
      busy_cnt_r <= busy_cnt_r - 16'h0001;
    end
  end

  assign nv_busy = busy_cnt_r != 16'h0000;
  assign divisor = {1'b0, regs.divider_value[15:tw_pkg::DIV_VAL_LSB]} + tw_pkg::DIV_OFFSET;
  assign sda_o   = 1'b0;
  assign sda_oe  = (st_r == tw_pkg::ST_ACK && ack_r) || (st_r == tw_pkg::ST_TX && !tx_r[7]);

  tw_pkg::tw_state_e st_prev_r;
  always_ff @(posedge clk) st_prev_r <= reset ? tw_pkg::ST_IDLE : st_r;

  property p_ack_match;
    @(posedge clk) disable iff (reset)
      byte_end && phase_r == tw_pkg::PH_CTRL && !ctrl_match |=> !ack_r && !sda_oe;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("control byte acked without match");

  property p_busy_nack;
    @(posedge clk) disable iff (reset)
      st_r == tw_pkg::ST_ACK && st_prev_r != tw_pkg::ST_ACK && $past(nv_busy) |-> !ack_r;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack given during nv write");

  property p_pd_nack;
    @(posedge clk) disable iff (reset)
      st_r == tw_pkg::ST_ACK && st_prev_r != tw_pkg::ST_ACK && $past(pd_s) |-> !sda_oe;
  endproperty
  a_pd_nack: assert property (p_pd_nack) else $error("ack given during power-down");

  property p_read_dir;
    @(posedge clk) disable iff (reset)
      st_r == tw_pkg::ST_TX && $past(st_r) == tw_pkg::ST_ACK |-> rw_r && phase_r == tw_pkg::PH_CTRL;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("transmit without read request");

  property p_div_hi;
    @(posedge clk) disable iff (reset)
      wr_stb && cmd_r == tw_pkg::CMD_DIV && idx_r == 2'h0 |=> regs.divider_value[15:8] == $past(rx_r);
  endproperty
  a_div_hi: assert property (p_div_hi) else $error("divider high byte not stored");

  property p_mux_lo;
    @(posedge clk) disable iff (reset)
      wr_stb && cmd_r == tw_pkg::CMD_MUX && idx_r == 2'h1 |=> regs.output_mux_config[7:0] == $past(rx_r);
  endproperty
  a_mux_lo: assert property (p_mux_lo) else $error("mux low byte not stored");

  property p_bus_rsvd;
    @(posedge clk) disable iff (reset)
      regs.bus_address_config[7:4] == 4'h0;
  endproperty
  a_bus_rsvd: assert property (p_bus_rsvd) else $error("reserved bus bits set");

  property p_bus_commit;
    @(posedge clk) disable iff (reset)
      commit_bus && !nv_busy |=> nv_busy && nv_image == regs;
  endproperty
  a_bus_commit: assert property (p_bus_commit) else $error("bus write did not commit");

  property p_wc_gate;
    @(posedge clk) disable iff (reset)
      !nv_busy && regs.bus_address_config[tw_pkg::BUS_WC_BIT] && !commit_cmd && !commit_bus |=> !nv_busy;
  endproperty
  a_wc_gate: assert property (p_wc_gate) else $error("commit without command while gated");

  property p_auto_commit;
    @(posedge clk) disable iff (reset)
      commit_end |=> nv_busy && nv_image == $past(regs);
  endproperty
  a_auto_commit: assert property (p_auto_commit) else $error("no auto commit at end of command");

  property p_divisor;
    @(posedge clk) disable iff (reset)
      regs.divider_value[15:6] == 10'h3FF |-> divisor == 11'h401;
  endproperty
  a_divisor: assert property (p_divisor) else $error("divisor offset wrong");
endmodule

// File: rtl/tw_sync.sv
`timescale 1ns/10ps
module tw_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // async in, synced out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// File: verif/tb.sv
`timescale 1ns/10ps
module tb;
  localparam logic [3:0] TYPE_CODE = 4'h5; // arbitrary value
  localparam int         NV_CYC    = 120;
  logic             clk, reset, power_down, scl, sda_low, sda, sda_o, sda_oe, nv_busy, ack;
  logic [10:0]      divisor;
  logic [15:0]      v, rd;
  logic [2:0]       sel;
  tw_pkg::tw_regs_s regs, nv_image, snap;
  int               mismatches, cmp_count, seed;
  assign sda = !(sda_low || sda_oe);
  tw_slave #(.TYPE_CODE(TYPE_CODE), .NV_WRITE_CYCLES(NV_CYC)) u_tw_slave (.clk(clk), .reset(reset),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .power_down(power_down),
    .regs(regs), .nv_image(nv_image), .nv_busy(nv_busy), .divisor(divisor));
  tw_master u_tw_master (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [10:0] exp_div(input logic [15:0] d);
    return 11'(d[15:tw_pkg::DIV_VAL_LSB]) + tw_pkg::DIV_OFFSET;
  endfunction
  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic ctrl(input logic [3:0] tc, input logic [2:0] s, input logic rw, input logic exp);
    u_tw_master.start();
    u_tw_master.send({tc, s, rw}, ack);
    chk(ack, exp);
  endtask
  task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] d);
    ctrl(TYPE_CODE, sel, 1'b0, 1'b1);
    u_tw_master.send(cmd, ack);
    chk(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_tw_master.send(i == 0 ? d[15:8] : d[7:0], ack);
      chk(ack, 1'b1);
    end
    u_tw_master.stop();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic rdr(input logic [7:0] cmd, input int n, output logic [15:0] d);
    d = 16'h0000;
    ctrl(TYPE_CODE, sel, 1'b0, 1'b1);
    u_tw_master.send(cmd, ack);
    chk(ack, 1'b1);
    ctrl(TYPE_CODE, sel, 1'b1, 1'b1);
    u_tw_master.recv(n == 1, d[15:8]);
    if (n == 2) u_tw_master.recv(1'b1, d[7:0]);
    u_tw_master.stop();
  endtask
  // refused address, then release the bus
  task automatic refused(input logic [3:0] tc, input logic [2:0] s);
    ctrl(tc, s, 1'b0, 1'b0);
    u_tw_master.stop();
  endtask
  task automatic nvw();
    for (int i = 0; i < 400 && nv_busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk(nv_busy, 1'b0);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    summarize();
  end
  initial begin
    reset      = 1'b1;
    power_down = 1'b0;
    seed       = 32'h83d2;
    sel        = 3'h0;
    mismatches = 0;
    cmp_count  = 0;
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(regs, 40'h0);
    chk(nv_image, 40'h0);
    chk(divisor, exp_div(16'h0000));
    chk(sda_oe, 1'b0);
    chk(sda_o, 1'b0);
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 16'hFFFF : 16'($random(seed));
      wr(tw_pkg::CMD_DIV, 2, v);
      chk(regs.divider_value, v);
      chk(divisor, exp_div(v));
      chk(nv_busy, 1'b1);
      chk(nv_image, regs);
      refused(TYPE_CODE, sel);
      nvw();
      rdr(tw_pkg::CMD_DIV, 2, rd);
      chk(rd, v);
      v = 16'($random(seed));
      wr(tw_pkg::CMD_MUX, 2, v);
      chk(regs.output_mux_config, v);
      nvw();
      rdr(tw_pkg::CMD_MUX, 2, rd);
      chk(rd, v);
    end
    v = regs.divider_value;
    wr(tw_pkg::CMD_DIV, 1, 16'hA500);
    chk(regs.divider_value, {8'hA5, v[7:0]});
    nvw();
    rdr(tw_pkg::CMD_DIV, 1, rd);
    chk(rd[15:8], 8'hA5);
    refused(~TYPE_CODE, sel);
    refused(TYPE_CODE, 3'h2);
    // commit bit set, select 5, reserved bits forced clear
    wr(tw_pkg::CMD_BUS, 1, 16'hFD00);
    chk(regs.bus_address_config, 8'h0D);
    chk(nv_busy, 1'b1);
    chk(nv_image, regs);
    nvw();
    sel = 3'h5;
    refused(TYPE_CODE, 3'h0);
    rdr(tw_pkg::CMD_BUS, 1, rd);
    chk(rd[15:8], 8'h0D);
    snap = nv_image;
    wr(tw_pkg::CMD_MUX, 2, 16'h5AA5);
    chk(nv_busy, 1'b0);
    chk(nv_image, snap);
    wr(tw_pkg::CMD_COMMIT, 0, 16'h0000);
    chk(nv_busy, 1'b1);
    chk(nv_image, regs);
    nvw();
    power_down = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    refused(TYPE_CODE, sel);
    power_down = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rdr(tw_pkg::CMD_MUX, 2, rd);
    chk(rd, 16'h5AA5);
    summarize();
  end
endmodule

// File: verif/tw_master.sv
`timescale 1ns/10ps
module tw_master (
  // clock
  input  wire logic clk,
  // bus wires
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // quarter of a 400 ns bus period
  task automatic q();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // also serves as repeated start
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule
